// ### verilog/scwp_control_serial_port.sv
// control serial port slave: two-word writes into a command queue, status word out
`timescale 1ns/10ps
`default_nettype none
`include "scwp_defines.svh"

module scwp_control_serial_port #(
  parameter int         QUEUE_DEPTH = `SCWP_QUEUE_DEPTH,
  parameter logic [3:0] BOARD_ID    = `SCWP_BOARD_ID_DEF, // arbitrary value
  parameter logic [3:0] VERSION     = `SCWP_VERSION_DEF   // arbitrary value
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire scwp_pkg::scwp_pins_t  ctlPins,
  output logic                       ctlMiso,
  input  wire scwp_pkg::scwp_health_t health,
  output logic                       cmdValid,
  input  wire logic                  cmdReady,
  output scwp_pkg::scwp_cmd_t        cmdOut,
  output logic [6:0]                 queueFill,
  output logic                       cmdDropped,
  output logic                       frameError
);

  localparam int PW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;

  typedef struct packed {
    logic                sclkPrev;
    logic                csPrev;
    logic [5:0]          bitCnt;
    logic                reload;
    logic [31:0]         rxShift;
    logic [31:0]         txShift;
    scwp_pkg::scwp_phase_t phase;
    logic [31:0]         firstWord;
    logic [PW-1:0]       wrPtr;
    logic [PW-1:0]       rdPtr;
    logic [6:0]          fill;
    logic                dropped;
    logic                frameErr;
  } scwp_state_t;

  scwp_state_t            st_reg;
  scwp_state_t            st_next;
  scwp_pkg::scwp_cmd_t    queueMem [QUEUE_DEPTH];
  logic                   pushEn;
  scwp_pkg::scwp_cmd_t    pushCmd;

  // assemble the outgoing status word from live state
  function automatic logic [31:0] status_word(
    input scwp_pkg::scwp_phase_t  ph,
    input logic [6:0]             fl,
    input scwp_pkg::scwp_health_t h
  );
    logic [31:0] w;
    w = 32'h00000000; // unused bits read zero
    w[`SCWP_ST_PHASE] = (ph == scwp_pkg::SCWP_DATA_NEXT);
    w[`SCWP_ST_FILL_MSB:`SCWP_ST_FILL_LSB] = fl;
    w[`SCWP_ST_TX_DONE] = h.txRstDone;
    w[`SCWP_ST_TX_GT]   = h.txTransceiverInReset;
    w[`SCWP_ST_TX_CORE] = h.txCoreInReset;
    w[`SCWP_ST_TX_SYNC] = h.txSync;
    w[`SCWP_ST_RX_DONE] = h.rxRstDone;
    w[`SCWP_ST_RX_GT]   = h.rxTransceiverInReset;
    w[`SCWP_ST_RX_CORE] = h.rxCoreInReset;
    w[`SCWP_ST_RX_SYNC] = h.rxSync;
    w[`SCWP_ST_TX_EMPTY] = h.txEmpty;
    w[`SCWP_ST_TX_ERROR] = h.txError;
    w[`SCWP_ST_RX_FULL]  = h.rxFull;
    w[`SCWP_ST_RX_EMPTY] = h.rxEmpty;
    w[`SCWP_ST_RX_ERROR] = h.rxError;
    w[`SCWP_ST_ID_LSB +: 4]  = BOARD_ID;
    w[`SCWP_ST_VER_LSB +: 4] = VERSION;
    return w;
  endfunction : status_word

  // split a command word and its data into a queue entry
  function automatic scwp_pkg::scwp_cmd_t decode_cmd(
    input logic [31:0] first,
    input logic [31:0] data
  );
    scwp_pkg::scwp_cmd_t c;
    c.bank     = first[`SCWP_BANK_MSB:`SCWP_BANK_LSB];
    c.offset   = first[`SCWP_BANK_LSB-1:0];
    c.data     = data;
    c.bankCtrl = (c.bank == `SCWP_BANK_CTRL);
    c.bankRx   = (c.bank == `SCWP_BANK_RX);
    c.bankTx   = (c.bank == `SCWP_BANK_TX);
    return c;
  endfunction : decode_cmd

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    logic [PW-1:0] n;
    if (p == PW'(QUEUE_DEPTH - 1)) begin
      n = '0;
    end else begin
      n = p + PW'(1);
    end
    return n;
  endfunction : ptr_inc

  logic        sclkRise;
  logic        sclkFall;
  logic        frameStart;
  logic        frameEnd;
  logic [31:0] rxWord;
  logic        wordDone;
  logic        popEn;
  logic        queueFull;

  always_comb begin
    sclkRise   = ctlPins.sclk & ~st_reg.sclkPrev;
    sclkFall   = ~ctlPins.sclk & st_reg.sclkPrev;
    frameStart = ~ctlPins.csB & st_reg.csPrev;
    frameEnd   = ctlPins.csB & ~st_reg.csPrev;
    rxWord     = {st_reg.rxShift[30:0], ctlPins.mosi};
    // a word counts only when its 32nd bit arrives inside the frame
    wordDone   = ~ctlPins.csB & sclkRise & (st_reg.bitCnt == `SCWP_CNT_LAST);
    queueFull  = (st_reg.fill == 7'(QUEUE_DEPTH));
    popEn      = cmdReady & (st_reg.fill != 7'h00);
  end

  always_comb begin
    st_next  = st_reg;
    pushEn   = 1'b0;
    pushCmd  = decode_cmd(st_reg.firstWord, rxWord);
    st_next.sclkPrev = ctlPins.sclk;
    st_next.csPrev   = ctlPins.csB;
    st_next.dropped  = 1'b0;
    st_next.frameErr = 1'b0;

    if (frameStart) begin
      // fresh status for the first word of a frame
      st_next.txShift = status_word(st_reg.phase, st_reg.fill, health);
      st_next.bitCnt  = 6'h00;
      st_next.reload  = 1'b0;
    end else if (frameEnd) begin
      // a frame that stops mid-word loses only the partial word; phase and first word are kept
      st_next.frameErr = (st_reg.bitCnt != 6'h00);
      st_next.bitCnt   = 6'h00;
      st_next.reload   = 1'b0;
    end else if (~ctlPins.csB) begin
      if (sclkRise) begin
        st_next.rxShift = rxWord;
        st_next.bitCnt  = st_reg.bitCnt + 6'h01;
        if (wordDone) begin
          st_next.bitCnt = 6'h00;
          st_next.reload = 1'b1;
          if (st_reg.phase == scwp_pkg::SCWP_ADDR_NEXT) begin
            st_next.firstWord = rxWord;
            st_next.phase     = scwp_pkg::SCWP_DATA_NEXT;
          end else begin
            st_next.phase = scwp_pkg::SCWP_ADDR_NEXT;
            // only code 00 writes; reserved codes and polls queue nothing
            if (st_reg.firstWord[`SCWP_CMD_MSB:`SCWP_CMD_LSB] == `SCWP_CMD_WRITE &&
                st_reg.firstWord[`SCWP_BANK_MSB:0] != `SCWP_POLL_ADDR) begin
              if (queueFull) begin
                st_next.dropped = 1'b1;
              end else begin
                pushEn = 1'b1;
              end
            end
          end
        end
      end else if (sclkFall) begin
        if (st_reg.reload) begin
          // back-to-back words in one frame: status again, phase now updated
          st_next.txShift = status_word(st_reg.phase, st_reg.fill, health);
          st_next.reload  = 1'b0;
        end else begin
          st_next.txShift = {st_reg.txShift[30:0], 1'b0};
        end
      end
    end

    if (pushEn) begin
      st_next.wrPtr = ptr_inc(st_reg.wrPtr);
    end
    if (popEn) begin
      st_next.rdPtr = ptr_inc(st_reg.rdPtr);
    end
    // queue depth seen by the host, counted as pushes minus pops
    if (pushEn && !popEn) begin
      st_next.fill = st_reg.fill + 7'h01;
    end else if (popEn && !pushEn) begin
      st_next.fill = st_reg.fill - 7'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg.sclkPrev  <= 1'b0;
      st_reg.csPrev    <= 1'b1;
      st_reg.bitCnt    <= 6'h00;
      st_reg.reload    <= 1'b0;
      st_reg.rxShift   <= 32'h00000000;
      st_reg.txShift   <= 32'h00000000;
      st_reg.phase     <= scwp_pkg::SCWP_ADDR_NEXT;
      st_reg.firstWord <= 32'h00000000;
      st_reg.wrPtr     <= '0;
      st_reg.rdPtr     <= '0;
      st_reg.fill      <= `SCWP_FILL_RESET;
      st_reg.dropped   <= 1'b0;
      st_reg.frameErr  <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // queue storage has no reset: entries are only read below the fill level
  always_ff @(posedge clk_sys) begin
    if (pushEn) begin
      queueMem[st_reg.wrPtr] <= pushCmd;
    end
  end

  always_comb begin
    ctlMiso    = st_reg.txShift[31]; // status shifts out msb first
    cmdValid   = (st_reg.fill != 7'h00);
    cmdOut     = queueMem[st_reg.rdPtr];
    queueFill  = st_reg.fill;
    cmdDropped = st_reg.dropped;
    frameError = st_reg.frameErr;
  end

endmodule : scwp_control_serial_port
`default_nettype wire

// ### verilog/scwp_defines.svh
// constants for the control serial port command front end
//
// Overview of operation
// - every control transfer is one whole 32-bit word, shifted as one unit
// - first word holds a 2-bit command code and a 30-bit target address
// - second word holds the 32-bit payload stored at that address
// - each word transfer returns one 32-bit status word, twice per write
// - command code 00 is a register write; other codes are reserved
// - 30-bit write space splits into one-megabyte banks chosen by upper bits
// - addresses count bytes, but only whole 32-bit words are written
// - one read-only status word; the register space is write-only
// - status bit 31 set when the next word is a data word
// - status bits 30:24 give the number of queued commands awaiting execution
// - status bit 23 is 1 once the transmit reset sequence is done
// - status bit 16 mirrors the live receiver synchronisation output
// - a write to bank zero offset 0x0 refreshes status and queues nothing
// - status bits 7:4 hold the board identifier, bits 3:0 the version
// - bank 0 is subsystem control, bank 1 receiver core, bank 2 transmitter core
`ifndef SCWP_DEFINES_SVH
`define SCWP_DEFINES_SVH

`define SCWP_WORD_BITS      32
`define SCWP_CNT_LAST       6'h1f
`define SCWP_CMD_MSB        31
`define SCWP_CMD_LSB        30
`define SCWP_CMD_WRITE      2'h0
`define SCWP_BANK_MSB       29
`define SCWP_BANK_LSB       20
`define SCWP_BANK_CTRL      10'h000
`define SCWP_BANK_RX        10'h001
`define SCWP_BANK_TX        10'h002
`define SCWP_POLL_ADDR      30'h00000000

`define SCWP_ST_PHASE       31
`define SCWP_ST_FILL_MSB    30
`define SCWP_ST_FILL_LSB    24
`define SCWP_ST_TX_DONE     23
`define SCWP_ST_TX_GT       22
`define SCWP_ST_TX_CORE     21
`define SCWP_ST_TX_SYNC     20
`define SCWP_ST_RX_DONE     19
`define SCWP_ST_RX_GT       18
`define SCWP_ST_RX_CORE     17
`define SCWP_ST_RX_SYNC     16
`define SCWP_ST_TX_EMPTY    13
`define SCWP_ST_TX_ERROR    12
`define SCWP_ST_RX_FULL     10
`define SCWP_ST_RX_EMPTY    9
`define SCWP_ST_RX_ERROR    8
`define SCWP_ST_ID_LSB      4
`define SCWP_ST_VER_LSB     0

`define SCWP_FILL_RESET     7'h00
`define SCWP_BOARD_ID_DEF   4'h5
`define SCWP_VERSION_DEF    4'h1
`define SCWP_QUEUE_DEPTH    16

`endif

// ### verilog/scwp_pkg.sv
// types shared by the control serial port command front end
`default_nettype none
package scwp_pkg;

  typedef enum logic {SCWP_ADDR_NEXT, SCWP_DATA_NEXT} scwp_phase_t;

  // live system state that the status word reports
  typedef struct packed {
    logic txRstDone;
    logic txTransceiverInReset;
    logic txCoreInReset;
    logic txSync;
    logic rxRstDone;
    logic rxTransceiverInReset;
    logic rxCoreInReset;
    logic rxSync;
    logic txEmpty;
    logic txError;
    logic rxFull;
    logic rxEmpty;
    logic rxError;
  } scwp_health_t;

  // one decoded write waiting for execution
  typedef struct packed {
    logic [9:0]  bank;
    logic [19:0] offset;
    logic [31:0] data;
    logic        bankCtrl;
    logic        bankRx;
    logic        bankTx;
  } scwp_cmd_t;

  // serial pins of the control port
  typedef struct packed {
    logic sclk;
    logic csB;
    logic mosi;
  } scwp_pins_t;

endpackage : scwp_pkg
`default_nettype wire

// ### tb/scwp_chk.sv
// port checker for the control serial port front end, bound into the design
`timescale 1ns/10ps
`default_nettype none
module scwp_chk #(
  parameter int QUEUE_DEPTH = 16
) (
  input wire logic                 clk_sys,
  input wire logic                 rst_b,
  input wire scwp_pkg::scwp_pins_t ctlPins,
  input wire logic                 ctlMiso,
  input wire logic                 cmdValid,
  input wire logic                 cmdReady,
  input wire scwp_pkg::scwp_cmd_t  cmdOut,
  input wire logic [6:0]           queueFill,
  input wire logic                 cmdDropped,
  input wire logic                 frameError
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  valid_fill_a: assert property (cmdValid == (queueFill != 7'h00))
    else $error("valid flag disagrees with fill");
  fill_bound_a: assert property (queueFill <= QUEUE_DEPTH)
    else $error("fill above depth");
  pop_step_a: assert property (cmdValid && cmdReady |=> queueFill <= $past(queueFill))
    else $error("pop did not lower fill");
  fill_step_a: assert property (1'b1 |=> queueFill <= $past(queueFill) + 7'h01)
    else $error("fill rose by more than one");
  drop_full_a: assert property (cmdDropped |-> $past(queueFill) == QUEUE_DEPTH)
    else $error("drop while queue not full");
  drop_pulse_a: assert property (cmdDropped |=> !cmdDropped)
    else $error("drop pulse too long");
  frame_err_a: assert property (frameError |->
    ($past(ctlPins.csB) && !$past(ctlPins.csB, 2)) ||
    ($past(ctlPins.csB, 2) && !$past(ctlPins.csB, 3)))
    else $error("frame error without select release");
  head_hold_a: assert property (cmdValid && !cmdReady |=> cmdValid && $stable(cmdOut))
    else $error("head entry moved without pop");
  bank_flag_a: assert property (cmdValid |->
    cmdOut.bankCtrl == (cmdOut.bank == 10'h000) && cmdOut.bankRx == (cmdOut.bank == 10'h001)
    && cmdOut.bankTx == (cmdOut.bank == 10'h002))
    else $error("bank flags wrong");
  miso_hold_a: assert property ($changed(ctlMiso) |->
    ($past(ctlPins.sclk, 2) && !$past(ctlPins.sclk)) ||
    ($past(ctlPins.sclk, 3) && !$past(ctlPins.sclk, 2)) ||
    ($past(ctlPins.csB, 2) && !$past(ctlPins.csB)) ||
    ($past(ctlPins.csB, 3) && !$past(ctlPins.csB, 2)))
    else $error("status bit moved outside a shift step");
endmodule : scwp_chk
bind scwp_control_serial_port scwp_chk #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_scwp_chk (
  .clk_sys, .rst_b, .ctlPins, .ctlMiso, .cmdValid, .cmdReady, .cmdOut, .queueFill,
  .cmdDropped, .frameError);
`default_nettype wire

// ### tb/scwp_host_model.sv
// host side serial master, mode 0, msb first
`timescale 1ns/10ps
`default_nettype none
module scwp_host_model (
  input wire logic               clk_sys,
  input wire logic               ctlMiso,
  output var scwp_pkg::scwp_pins_t ctlPins
);
  initial ctlPins = 3'b010;
  task automatic go(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : go
  // each level held two system cycles so the slave sees every edge
  task automatic word(input logic [31:0] w, input int n, output logic [31:0] s);
    s = 32'h0;
    for (int i = 31; i > 31 - n; i--) begin
      ctlPins.mosi = w[i];
      go(2);
      s[i] = ctlMiso;
      ctlPins.sclk = 1'b1;
      go(2);
      ctlPins.sclk = 1'b0;
    end
  endtask : word
  task automatic frame(input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] s0, output logic [31:0] s1);
    ctlPins.csB = 1'b0;
    go(2);
    word(a, 32, s0);
    word(d, 32, s1);
    go(2);
    ctlPins.csB = 1'b1;
    ctlPins.mosi = ~d[0]; // a released line does not keep its last bit
    go(3);
  endtask : frame
  task automatic part(output logic [31:0] s);
    ctlPins.csB = 1'b0;
    go(2);
    word(32'hffffffff, 8, s);
    go(2);
    ctlPins.csB = 1'b1;
    ctlPins.mosi = 1'b0; // a released line does not keep its last bit
    go(3);
  endtask : part
endmodule : scwp_host_model
`default_nettype wire

// ### tb/spi_control_write_port_tb_top.sv
// self-checking bench for the control serial port front end
`timescale 1ns/10ps
`default_nettype none
module spi_control_write_port_tb_top;
  logic                   clk_sys, rst_b, cmdReady, ctlMiso, cmdValid, cmdDropped, frameError;
  logic [6:0]             queueFill;
  logic [31:0]            s0, s1;
  scwp_pkg::scwp_pins_t   ctlPins;
  scwp_pkg::scwp_health_t health;
  scwp_pkg::scwp_cmd_t    cmdOut;
  scwp_pkg::scwp_cmd_t    expQ[$];
  int                     failures, comparisons, fill, drops, cuts;
  scwp_control_serial_port #(.QUEUE_DEPTH(2), .BOARD_ID(4'ha), .VERSION(4'h3))
    u_scwp_control_serial_port (.clk_sys(clk_sys), .rst_b(rst_b), .ctlPins(ctlPins),
    .ctlMiso(ctlMiso), .health(health), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOut(cmdOut), .queueFill(queueFill), .cmdDropped(cmdDropped), .frameError(frameError));
  scwp_host_model u_scwp_host_model (.clk_sys(clk_sys), .ctlMiso(ctlMiso), .ctlPins(ctlPins));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // one-cycle pulses are counted mid-cycle, where they stand settled
  always @(negedge clk_sys) begin
    if (cmdDropped)
      drops++;
    if (frameError)
      cuts++;
  end
  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] st(input logic ph);
    st = {ph, 7'(fill), health[12:5], 2'h0, health[4:3], 1'h0, health[2:0], 4'ha, 4'h3};
  endfunction : st
  task automatic wr(input logic [1:0] c, input logic [29:0] a, input logic [31:0] v);
    health = 13'($urandom);
    u_scwp_host_model.frame({c, a}, v, s0, s1);
    check(s0, st(1'h0));
    check(s1, st(1'h1));
    if (c == 2'h0 && a != 30'h0 && fill < 2) begin
      expQ.push_back({a[29:20], a[19:0], v, a[29:20] == 10'h0, a[29:20] == 10'h1,
                      a[29:20] == 10'h2});
      fill++;
    end
    check(queueFill, 65'(fill));
  endtask : wr
  task automatic drain;
    cmdReady = 1'b1;
    while (expQ.size() > 0) begin
      check(cmdValid, 65'h1);
      check(cmdOut, expQ.pop_front());
      @(negedge clk_sys);
      fill--;
    end
    cmdReady = 1'b0;
    check(cmdValid, 65'h0);
  endtask : drain
  task automatic test_done;
    $display("counts failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    #400000;
    failures++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    cmdReady = 1'b0;
    health = '0;
    void'($urandom(32'h7d77d72e));
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(queueFill, 65'h0);
    // fill past depth two so the third write is dropped
    wr(2'h0, 30'h00000010, $urandom);
    wr(2'h0, 30'h00100004, $urandom);
    wr(2'h0, 30'h00200008, $urandom);
    wr(2'h0, 30'h00000000, $urandom);
    drain();
    check(65'(drops), 65'h1);
    $display("test queue and drop done");
    for (int c = 1; c < 4; c++)
      wr(2'(c), 30'h00100020, $urandom);
    u_scwp_host_model.part(s0);
    check(s0, st(1'h0) & 32'hff000000);
    check(65'(cuts), 65'h1);
    wr(2'h0, 30'h0000000c, $urandom);
    drain();
    $display("test reserved and partial done");
    for (int i = 0; i < 6; i++) begin
      wr(2'h0, {10'($urandom_range(2)), 18'($urandom), 2'h0}, $urandom);
      if (i % 2 == 1)
        drain();
    end
    check(65'(drops + cuts), 65'h2);
    $display("test random writes done");
    test_done();
  end
endmodule : spi_control_write_port_tb_top
`default_nettype wire
